// ==== logic/stmr_consts.svh ====
// Register indices, field positions, reset values and counts of the 16-bit timer
`ifndef STMR_CONSTS_SVH
`define STMR_CONSTS_SVH

// Register indices; the byte address is four times the index
`define STMR_IDX_INTCTL     8'h0b
`define STMR_IDX_IRQFLG     8'h0c
`define STMR_IDX_CNTLO      8'h0e
`define STMR_IDX_CNTHI      8'h0f
`define STMR_IDX_CTRL       8'h10
`define STMR_IDX_IRQEN      8'h8c

// Bus widths
`define STMR_ADDR_W         10
`define STMR_DATA_W         32

// Field positions
`define STMR_BIT_OVF        0
`define STMR_BIT_PERIPH     6
`define STMR_BIT_GLOBAL     7
`define STMR_BIT_OSCEN      3

// Reset values and masks
`define STMR_CTRL_RST       8'h00
`define STMR_CTRL_MASK      8'h3f
`define STMR_IRQ_RST        8'h00
`define STMR_INTCTL_RST     8'h00
`define STMR_INTCTL_KEEP    8'h01
`define STMR_RDATA_RST      32'h0000_0000

// Compare mode that issues the clearing trigger
`define STMR_TRIG_MODE      4'hb

// Counts
`define STMR_INSTR_DIV_LAST 2'h3
`define STMR_CNT_MAX        16'hffff
`define STMR_CNT_ZERO       16'h0000
`define STMR_PRESC_FULL     3'h7

`endif

// ==== logic/stmr_pkg.sv ====
// Types shared by the 16-bit timer modules
package stmr_pkg;

    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] prescale_select;
        logic       sec_osc_enable;
        logic       ext_sync_disable;
        logic       clock_source_select;
        logic       timer_run_bit;
    } stmr_ctrl_s;

    typedef struct packed {
        logic [3:0] compare_mode_field;
        logic       event_pulse;
    } stmr_cmp_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } stmr_bus_e;

endpackage

// ==== logic/stmr_rise_detect.sv ====
// Rising edge detector for the external count input
`timescale 1ns/1ps
module stmr_rise_detect (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic level_i,
    output logic      rise_o
);
    logic prev_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_r;

endmodule

// ==== logic/stmr_prescaler.sv ====
// Selectable 1:1 to 1:8 prescaler with clear
`timescale 1ns/1ps
`include "stmr_consts.svh"
module stmr_prescaler (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [1:0] select_i,
    output logic            tick_o
);
    logic [2:0] count_r;
    logic [2:0] count_nxt;
    wire  [2:0] mask_w = {select_i == 2'b11, select_i[1], |select_i};
    wire        last_w = (count_r & mask_w) == mask_w;

    assign tick_o    = tick_i & last_w;
    assign count_nxt = clear_i ? 3'h0 : (tick_i ? count_r + 3'h1 : count_r);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= 3'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    presc_clear_a: assert property (clear_i |=> count_r == 3'h0)
        else $error("prescaler not cleared after count write");
    presc_ratio_a: assert property (tick_o && select_i == 2'b11 |-> count_r == `STMR_PRESC_FULL)
        else $error("1:8 prescale emitted early");

endmodule

// ==== logic/stmr_timer.sv ====
// 16-bit timer/counter with prescaler, trigger clear and Avalon-MM registers
`timescale 1ns/1ps
`include "stmr_consts.svh"

// Notes on behaviour
// - Oscillator enable follows control bit three
// - Oscillator keeps running during halt
// - Mode 1011 trigger clears the count
// - Trigger clear never sets overflow flag
// - Count write beats simultaneous trigger
// - Compare pair sets the counting period
// - Count bytes survive every reset
// - Control clears on power-on only
// - Count byte write clears prescaler
// - Prescale field divides 1,2,4,8
// - Source bit picks instruction or external
// - Unsynchronised mode counts during halt
// - Synchronised mode holds count during halt
module stmr_timer
    import stmr_pkg::*;
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     other_reset_i,
    input  wire logic                     sleep_i,
    input  wire logic                     ext_clk_i,
    input  wire logic                     osc_input_pin_i,
    input  wire stmr_cmp_s                compare_unit_a_i,
    input  wire stmr_cmp_s                compare_unit_b_i,
    input  wire logic [`STMR_ADDR_W-1:0]  avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [`STMR_DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [`STMR_DATA_W-1:0]  avs_readdata_o,
    output logic                          avs_waitrequest_o,
    output logic                          sec_osc_enable_o,
    output logic      [15:0]              timer_count_o,
    output logic                          overflow_irq_o
);

    // Bus slave state
    stmr_bus_e                bus_state_r;
    stmr_bus_e                bus_nxt;
    logic [`STMR_DATA_W-1:0]  readdata_r;

    // Registers
    stmr_ctrl_s               ctrl_r;
    logic [7:0]               irq_flags_r;
    logic [7:0]               irq_flags_nxt;
    logic [7:0]               irq_en_r;
    logic [7:0]               intctl_r;
    logic [15:0]              count_r;
    logic [15:0]              count_nxt;
    logic [1:0]               div_r;
    logic                     sync_tick_r;
    logic                     irq_r;
    logic [1:0]               count_known_r;

    // Bus decode
    wire        req_w     = avs_read_i | avs_write_i;
    wire        acked_w   = bus_state_r == BUS_ACK;
    wire        wr_fire_w = avs_write_i & acked_w & avs_byteenable_i[0];
    wire        rd_take_w = avs_read_i & (bus_state_r == BUS_IDLE);
    wire [7:0]  idx_w     = avs_address_i[`STMR_ADDR_W-1:2];
    wire [7:0]  wdata_w   = avs_writedata_i[7:0];

    wire        sel_intctl_w = idx_w == `STMR_IDX_INTCTL;
    wire        sel_irqflg_w = idx_w == `STMR_IDX_IRQFLG;
    wire        sel_cntlo_w  = idx_w == `STMR_IDX_CNTLO;
    wire        sel_cnthi_w  = idx_w == `STMR_IDX_CNTHI;
    wire        sel_ctrl_w   = idx_w == `STMR_IDX_CTRL;
    wire        sel_irqen_w  = idx_w == `STMR_IDX_IRQEN;

    wire        wr_intctl_w = wr_fire_w & sel_intctl_w;
    wire        wr_irqflg_w = wr_fire_w & sel_irqflg_w;
    wire        wr_cntlo_w  = wr_fire_w & sel_cntlo_w;
    wire        wr_cnthi_w  = wr_fire_w & sel_cnthi_w;
    wire        wr_ctrl_w   = wr_fire_w & sel_ctrl_w;
    wire        wr_irqen_w  = wr_fire_w & sel_irqen_w;
    wire        count_write_w = wr_cntlo_w | wr_cnthi_w;

    // Unmapped reads return zero
    wire [7:0]  rd_mux_w = sel_intctl_w ? intctl_r :
                           sel_irqflg_w ? irq_flags_r :
                           sel_cntlo_w  ? count_r[7:0] :
                           sel_cnthi_w  ? count_r[15:8] :
                           sel_ctrl_w   ? (ctrl_r & `STMR_CTRL_MASK) :
                           sel_irqen_w  ? irq_en_r : 8'h00;

    // One wait state on every access
    assign avs_waitrequest_o = req_w & ~acked_w;
    assign avs_readdata_o    = readdata_r;

    always_comb begin
        case (bus_state_r)
            BUS_IDLE: begin
                bus_nxt = req_w ? BUS_ACK : BUS_IDLE;
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state_r <= BUS_IDLE;
            readdata_r  <= `STMR_RDATA_RST;
        end else begin
            bus_state_r <= bus_nxt;
            if (rd_take_w) begin
                readdata_r <= {24'h00_0000, rd_mux_w};
            end
        end
    end

    // Clock sources
    wire        run_w      = ctrl_r.timer_run_bit;
    wire        css_w      = ctrl_r.clock_source_select;
    wire        nosync_w   = ctrl_r.ext_sync_disable;
    // Main oscillator stops in halt, so the instruction tick does too
    wire        instr_tick_w = (div_r == `STMR_INSTR_DIV_LAST) & ~sleep_i;
    wire        ext_level_w  = ctrl_r.sec_osc_enable ? osc_input_pin_i : ext_clk_i;
    wire        ext_rise_w;
    wire        presc_in_w   = run_w & (css_w ? ext_rise_w : instr_tick_w);
    wire        presc_tick_w;

    stmr_rise_detect u_rise (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .level_i   (ext_level_w),
        .rise_o    (ext_rise_w)
    );

    stmr_prescaler u_presc (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clear_i   (count_write_w | other_reset_i),
        .tick_i    (presc_in_w),
        .select_i  (ctrl_r.prescale_select),
        .tick_o    (presc_tick_w)
    );

    // Synchronised path adds one stage after the prescaler and stops in halt
    wire        sync_inc_w  = sync_tick_r & ~sleep_i;
    wire        ext_inc_w   = nosync_w ? presc_tick_w : sync_inc_w;
    wire        inc_w       = run_w & (css_w ? ext_inc_w : presc_tick_w);

    // Compare triggers; the compare match itself sets the period
    wire        trig_a_w = compare_unit_a_i.event_pulse &
                           (compare_unit_a_i.compare_mode_field == `STMR_TRIG_MODE);
    wire        trig_b_w = compare_unit_b_i.event_pulse &
                           (compare_unit_b_i.compare_mode_field == `STMR_TRIG_MODE);
    wire        trig_w   = trig_a_w | trig_b_w;
    wire        trig_clr_w = trig_w & ~count_write_w;

    wire [15:0] count_wr_w  = {wr_cnthi_w ? wdata_w : count_r[15:8],
                               wr_cntlo_w ? wdata_w : count_r[7:0]};
    wire [15:0] count_inc_w = count_r + 16'h0001;

    // Write beats trigger; trigger beats increment
    assign count_nxt = count_write_w ? count_wr_w :
                       trig_w        ? `STMR_CNT_ZERO :
                       inc_w         ? count_inc_w : count_r;

    // Rollover only by counting, never by a trigger clear
    wire        ovf_set_w = inc_w & ~count_write_w & ~trig_w & (count_r == `STMR_CNT_MAX);

    // Set wins over a software clear in the same cycle
    assign irq_flags_nxt = (wr_irqflg_w ? wdata_w : irq_flags_r) |
                           {7'h00, ovf_set_w};

    wire        irq_cond_w = irq_flags_r[`STMR_BIT_OVF] & irq_en_r[`STMR_BIT_OVF] &
                             intctl_r[`STMR_BIT_PERIPH] & intctl_r[`STMR_BIT_GLOBAL];

    // Count has no reset at all so it survives every reset
    always_ff @(posedge ref_clk_i) begin
        count_r <= count_nxt;
    end

    // Stability checks wait until both bytes were loaded; power-up leaves them unknown
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_known_r <= 2'b00;
        end else begin
            count_known_r <= count_known_r | {wr_cnthi_w | trig_clr_w, wr_cntlo_w | trig_clr_w};
        end
    end

    // Control register sees only the power-on reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= `STMR_CTRL_RST;
        end else if (wr_ctrl_w) begin
            ctrl_r <= wdata_w & `STMR_CTRL_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_flags_r <= `STMR_IRQ_RST;
            irq_en_r    <= `STMR_IRQ_RST;
            intctl_r    <= `STMR_INTCTL_RST;
        end else if (other_reset_i) begin
            irq_flags_r <= `STMR_IRQ_RST;
            irq_en_r    <= `STMR_IRQ_RST;
            intctl_r    <= intctl_r & `STMR_INTCTL_KEEP;
        end else begin
            irq_flags_r <= irq_flags_nxt;
            if (wr_irqen_w) begin
                irq_en_r <= wdata_w;
            end
            if (wr_intctl_w) begin
                intctl_r <= wdata_w;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r       <= 2'h0;
            sync_tick_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            div_r       <= div_r + 2'h1;
            sync_tick_r <= presc_tick_w;
            irq_r       <= irq_cond_w;
        end
    end

    // Oscillator enable is not gated by halt
    assign sec_osc_enable_o = ctrl_r.sec_osc_enable;
    assign timer_count_o    = count_r;
    assign overflow_irq_o   = irq_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    osc_enable_a: assert property (
        wr_ctrl_w |=> sec_osc_enable_o == $past(avs_writedata_i[`STMR_BIT_OSCEN]))
        else $error("oscillator enable does not follow control write");

    osc_in_halt_a: assert property (
        sleep_i && sec_osc_enable_o && !wr_ctrl_w |=> sec_osc_enable_o)
        else $error("oscillator stopped during halt");

    trig_clear_a: assert property (
        trig_w && !count_write_w |=> timer_count_o == `STMR_CNT_ZERO)
        else $error("trigger did not clear the count");

    trig_no_flag_a: assert property (
        trig_w && !wr_irqflg_w && !other_reset_i && !irq_flags_r[`STMR_BIT_OVF]
        |=> !irq_flags_r[`STMR_BIT_OVF])
        else $error("trigger clear set the overflow flag");

    write_wins_a: assert property (
        trig_w && wr_cntlo_w |=> timer_count_o[7:0] == $past(avs_writedata_i[7:0]))
        else $error("trigger overrode a count write");

    period_wrap_a: assert property (
        trig_w && !count_write_w ##1 inc_w && !trig_w && !count_write_w
        |=> timer_count_o == 16'h0001)
        else $error("count did not restart from zero after trigger");

    count_kept_a: assert property (
        &count_known_r && other_reset_i && !count_write_w && !trig_w && !inc_w |=> $stable(timer_count_o))
        else $error("count disturbed by reset");

    ctrl_kept_a: assert property (
        other_reset_i && !wr_ctrl_w |=> $stable(ctrl_r))
        else $error("control changed by a non power-on reset");

    timer_src_a: assert property (
        !css_w && inc_w |-> $past(instr_tick_w) || instr_tick_w)
        else $error("timer mode counted without instruction tick");

    async_halt_a: assert property (
        &count_known_r && run_w && css_w && nosync_w && presc_tick_w && !count_write_w && !trig_w
        |=> timer_count_o == $past(count_inc_w))
        else $error("unsynchronised count missed an edge");

    sync_halt_a: assert property (
        css_w && !nosync_w && sleep_i |-> !inc_w)
        else $error("synchronised count advanced in halt");

    run_hold_a: assert property (
        &count_known_r && !run_w && !count_write_w && !trig_w |=> $stable(timer_count_o))
        else $error("count moved with run bit clear");

    ovf_flag_a: assert property (
        ovf_set_w && !other_reset_i |=> irq_flags_r[`STMR_BIT_OVF] ##1 1'b1)
        else $error("rollover did not set overflow flag");

    irq_gate_a: assert property (
        irq_cond_w |=> overflow_irq_o)
        else $error("enabled overflow did not raise interrupt");

    irq_drop_a: assert property (
        !irq_cond_w |=> !overflow_irq_o)
        else $error("interrupt raised without enabled overflow");

    flag_sticky_a: assert property (
        irq_flags_r[`STMR_BIT_OVF] && !wr_irqflg_w && !other_reset_i |=> irq_flags_r[`STMR_BIT_OVF])
        else $error("overflow flag dropped without software clear");

    wrap_zero_a: assert property (
        ovf_set_w |=> timer_count_o == `STMR_CNT_ZERO)
        else $error("rollover did not land on zero");

    timer_halt_a: assert property (
        !css_w && sleep_i |-> !inc_w)
        else $error("timer mode counted in halt");

    sync_stage_a: assert property (
        &count_known_r && run_w && css_w && !nosync_w && !sleep_i && sync_tick_r && !count_write_w && !trig_w
        |=> timer_count_o == $past(count_inc_w))
        else $error("synchronised count missed a tick");

    run_gate_a: assert property (
        inc_w |-> run_w)
        else $error("increment with run bit clear");

    ctrl_write_a: assert property (
        wr_ctrl_w |=> ctrl_r == ($past(wdata_w) & `STMR_CTRL_MASK))
        else $error("control write not stored");

    one_wait_a: assert property (
        req_w && !acked_w |=> !avs_waitrequest_o)
        else $error("more than one wait state");

    ack_single_a: assert property (
        acked_w |=> !acked_w)
        else $error("acknowledge held longer than one cycle");

    read_data_a: assert property (
        rd_take_w |=> avs_readdata_o == {24'h00_0000, $past(rd_mux_w)})
        else $error("read data not presented in answer cycle");

endmodule

// ==== testbench/stmr_ext_model.sv ====
// External count source model: rising edges on the count pin or oscillator input
`timescale 1ns/1ps
module stmr_ext_model (
    input  wire logic       ref_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] edges_i,
    input  wire logic       use_osc_i,
    input  wire logic       slow_i,
    output logic            ext_clk_o,
    output logic            osc_o,
    output logic            busy_o
);
    logic [7:0] left_r;
    logic [2:0] ph_r;
    logic       lvl;

    initial begin
        left_r = 8'h00;
        ph_r   = 3'h0;
    end

    // High one cycle, then low two or five, so the sampler always sees a low between rises
    always @(posedge ref_clk_i) begin
        if (go_i && left_r == 8'h00) begin
            left_r <= edges_i;
            ph_r   <= 3'h0;
        end else if (left_r != 8'h00) begin
            ph_r <= (ph_r == (slow_i ? 3'h5 : 3'h2)) ? 3'h0 : ph_r + 3'h1;
            if (ph_r == (slow_i ? 3'h5 : 3'h2)) begin
                left_r <= left_r - 8'h01;
            end
        end
    end

    // Idle low between bursts; only the selected source pin toggles
    assign lvl       = (left_r != 8'h00) && (ph_r == 3'h0);
    assign ext_clk_o = !use_osc_i && lvl;
    assign osc_o     = use_osc_i && lvl;
    assign busy_o    = go_i || (left_r != 8'h00);
endmodule

// ==== testbench/stmr_timer_tb_top.sv ====
// Self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "stmr_consts.svh"
module stmr_timer_tb_top import stmr_pkg::*;;
    logic        ref_clk_i, rst_i, other_reset_i, sleep_i, ext_clk, osc_pin;
    logic        go, use_osc, slow, busy, rd, wr, ws_s, wreq, osc_en, irq;
    logic [7:0]  n_edges;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  be;
    logic [15:0] cnt, r;
    stmr_cmp_s   cmp_a, cmp_b;
    logic [31:0] expq[$];
    int          fails, num_checks, k;
    integer      seed;

    stmr_timer i_stmr_timer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .other_reset_i(other_reset_i),
        .sleep_i(sleep_i), .ext_clk_i(ext_clk), .osc_input_pin_i(osc_pin), .compare_unit_a_i(cmp_a),
        .compare_unit_b_i(cmp_b), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .sec_osc_enable_o(osc_en), .timer_count_o(cnt), .overflow_irq_o(irq));

    stmr_ext_model i_stmr_ext_model (.ref_clk_i(ref_clk_i), .go_i(go), .edges_i(n_edges),
        .use_osc_i(use_osc), .slow_i(slow), .ext_clk_o(ext_clk), .osc_o(osc_pin), .busy_o(busy));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Waitrequest as it stood during the cycle before each rising edge
    always @(negedge ref_clk_i) ws_s <= wreq;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read results are compared when the answer stands, against the oldest note
    always @(posedge ref_clk_i) if (rd && !ws_s) chk(rdata, expq.pop_front());

    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic trg);
        logic [31:0] rn;
        rn = $random(seed);
        addr  <= {idx, 2'b00};
        wr    <= w;
        rd    <= !w;
        wdata <= {rn[31:8], d};
        do begin
            @(posedge ref_clk_i);
            cmp_a.event_pulse <= trg && ws_s;
        end while (ws_s);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task wrt(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 1'b0);
    endtask

    task rdchk(input logic [7:0] idx, input logic [7:0] exp);
        expq.push_back({24'h0, exp});
        bus(1'b0, idx, 8'h00, 1'b0);
    endtask

    task cnt_chk(input logic [15:0] exp);
        chk({16'h0, cnt}, {16'h0, exp});
        rdchk(`STMR_IDX_CNTLO, exp[7:0]);
        rdchk(`STMR_IDX_CNTHI, exp[15:8]);
    endtask

    task set_cnt(input logic [15:0] v);
        wrt(`STMR_IDX_CNTLO, v[7:0]);
        wrt(`STMR_IDX_CNTHI, v[15:8]);
    endtask

    task pulses(input logic [7:0] n);
        int i;
        go      <= 1'b1;
        n_edges <= n;
        @(posedge ref_clk_i);
        go <= 1'b0;
        for (i = 0; i < 3000 && busy; i++) @(negedge ref_clk_i);
        if (busy) begin
            fails++;
            $display("unexpected at %0t: model busy %h expected %h", $time, busy, 1'b0);
        end
        repeat (4) @(posedge ref_clk_i);
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        conclude();
    end

    initial begin
        seed = 32'hde444676;
        {rst_i, other_reset_i, sleep_i, go, use_osc, slow, rd, wr} = 8'h80;
        {n_edges, addr, wdata, be} = {8'h00, 10'h000, 32'h0, 4'hf};
        cmp_a = '0;
        cmp_b = '0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdchk(`STMR_IDX_CTRL, 8'h00);
        rdchk(`STMR_IDX_IRQFLG, 8'h00);
        rdchk(`STMR_IDX_IRQEN, 8'h00);
        rdchk(`STMR_IDX_INTCTL, 8'h00);
        rdchk(8'h11, 8'h00);
        $display("test reset values done");
        r = 16'($random(seed));
        set_cnt(r);
        wrt(`STMR_IDX_CTRL, 8'h34);
        other_reset_i <= 1'b1;
        @(posedge ref_clk_i);
        other_reset_i <= 1'b0;
        @(posedge ref_clk_i);
        rdchk(`STMR_IDX_CTRL, 8'h34);
        cnt_chk(r);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdchk(`STMR_IDX_CTRL, 8'h00);
        cnt_chk(r);
        $display("test reset retention done");
        wrt(`STMR_IDX_CTRL, 8'h08);
        chk({31'h0, osc_en}, 32'h1);
        sleep_i <= 1'b1;
        repeat (50) @(posedge ref_clk_i);
        chk({31'h0, osc_en}, 32'h1);
        sleep_i <= 1'b0;
        wrt(`STMR_IDX_CTRL, 8'h00);
        chk({31'h0, osc_en}, 32'h0);
        $display("test oscillator enable done");
        for (k = 0; k < 4; k++) begin
            use_osc <= k[0];
            slow    <= k[1];
            set_cnt(16'h0000);
            wrt(`STMR_IDX_CTRL, {2'b00, k[1:0], k[0], 3'b011});
            pulses(8'd16);
            cnt_chk(16'd16 >> k);
        end
        use_osc <= 1'b0;
        // Timer mode: instruction clock is a quarter rate, ext edges ignored
        set_cnt(16'h0000);
        wrt(`STMR_IDX_CTRL, 8'h01);
        repeat (40) @(posedge ref_clk_i);
        wrt(`STMR_IDX_CTRL, 8'h00);
        chk({31'h0, cnt >= 16'd9 && cnt <= 16'd12}, 32'h1);
        $display("test prescale and source done");
        set_cnt(16'h0000);
        wrt(`STMR_IDX_CTRL, 8'h33);
        pulses(8'd5);
        wrt(`STMR_IDX_CNTLO, 8'h00);
        pulses(8'd11);
        cnt_chk(16'h0001);
        wrt(`STMR_IDX_CTRL, 8'h03);
        set_cnt(16'h0000);
        sleep_i <= 1'b1;
        pulses(8'd8);
        cnt_chk(16'h0000);
        wrt(`STMR_IDX_CTRL, 8'h07);
        pulses(8'd8);
        cnt_chk(16'h0008);
        wrt(`STMR_IDX_CTRL, 8'h06);
        pulses(8'd8);
        cnt_chk(16'h0008);
        sleep_i <= 1'b0;
        $display("test halt and run bit done");
        wrt(`STMR_IDX_IRQEN, 8'h01);
        wrt(`STMR_IDX_INTCTL, 8'hc0);
        set_cnt(16'hffff);
        wrt(`STMR_IDX_CTRL, 8'h03);
        pulses(8'd1);
        cnt_chk(16'h0000);
        rdchk(`STMR_IDX_IRQFLG, 8'h01);
        chk({31'h0, irq}, 32'h1);
        wrt(`STMR_IDX_INTCTL, 8'h40);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h0);
        wrt(`STMR_IDX_IRQFLG, 8'h00);
        $display("test overflow done");
        // Trigger tests run in synchronised mode, where the clear is dependable
        for (k = 0; k < 4; k++) begin
            r = 16'($random(seed));
            set_cnt(r);
            if (k[1]) cmp_b <= {k[0] ? 4'hb : 4'ha, 1'b1};
            else cmp_a <= {k[0] ? 4'hb : 4'ha, 1'b1};
            @(posedge ref_clk_i);
            cmp_a.event_pulse <= 1'b0;
            cmp_b.event_pulse <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            cnt_chk(k[0] ? 16'h0000 : r);
            rdchk(`STMR_IDX_IRQFLG, 8'h00);
        end
        set_cnt(16'h1234);
        cmp_a.compare_mode_field <= 4'hb;
        bus(1'b1, `STMR_IDX_CNTLO, 8'h55, 1'b1);
        cnt_chk(16'h1255);
        be <= 4'he;
        wrt(`STMR_IDX_CNTLO, 8'haa);
        be <= 4'hf;
        cnt_chk(16'h1255);
        // Compare partner: match at five, trigger lands one edge before the next tick
        set_cnt(16'h0000);
        wrt(`STMR_IDX_CTRL, 8'h01);
        for (k = 0; k < 200 && cnt != 16'd5; k++) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        cmp_a.event_pulse <= 1'b1;
        @(posedge ref_clk_i);
        cmp_a.event_pulse <= 1'b0;
        wrt(`STMR_IDX_CTRL, 8'h00);
        cnt_chk(16'h0001);
        $display("test trigger clear done");
        conclude();
    end
endmodule
